// ==== hdl/drs_pkg.sv ====
// Package of constants and types for the channel request-select block
// Assumes a 32-bit APB slave port and a single pclk domain
package drs_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] ADDR_REQ_SELECT = 12'h000;
    localparam logic [11:0] ADDR_STATUS     = 12'h004;

    // ----------------------------------------
    // Field layout
    // ----------------------------------------
    localparam int          SRC_W           = 7;
    localparam int          NUM_LINES       = 128;
    localparam int          FORCE_BIT       = 15;
    localparam logic [6:0]  SRC_RESET       = 7'h00;
    localparam int          RSV_HI          = 14;
    localparam int          RSV_LO          = 7;
    localparam int          BUSY_BIT        = 0;

    // ----------------------------------------
    // Carried groups
    // ----------------------------------------
    typedef struct packed {
        logic [SRC_W-1:0] source;
        logic             force_trig;
    } drs_ctrl_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01
    } drs_state_type;

endpackage

// ==== hdl/drs_sync.sv ====
// Two-flop synchroniser bank for the peripheral request lines
// Assumes the request lines come from outside the pclk domain
module drs_sync (
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // Lines
    input  wire logic [drs_pkg::NUM_LINES-1:0] lines_in,
    output logic      [drs_pkg::NUM_LINES-1:0] lines_out
);

    logic [drs_pkg::NUM_LINES-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q    <= '0;
            lines_out <= '0;
        end
        else
        begin
            meta_q    <= lines_in;
            lines_out <= meta_q;
        end
    end

endmodule

// ==== hdl/drs_mux.sv ====
// Request multiplexer: picks one line by its index
// Assumes synchronised lines on the same clock
module drs_mux (
    // Selection
    input  wire logic [drs_pkg::NUM_LINES-1:0] lines,
    input  wire logic [drs_pkg::SRC_W-1:0]     source,
    // Result
    output logic                               picked
);

    assign picked = lines[source];

endmodule

// ==== hdl/drs_top.sv ====
// Channel request-select and manual trigger logic with APB registers
// Assumes a transfer engine that returns a one-cycle xfer_done pulse
//
// Our own choices: the address map and the APB slave port.
module drs_top (
    // APB clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Peripheral request lines
    input  wire logic [drs_pkg::NUM_LINES-1:0] periph_req,
    // Transfer engine
    output logic                               channel_transfer_request,
    input  wire logic                          xfer_done
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    drs_pkg::drs_ctrl_type  ctrl_q;
    drs_pkg::drs_state_type state_q;
    logic [drs_pkg::NUM_LINES-1:0] lines_s;
    logic                          picked;
    logic                          picked_q;
    logic                          forced_q;
    logic                          wr_hit;
    logic                          access;

    assign access = psel & penable & pready;
    assign wr_hit = access & pwrite & (paddr == drs_pkg::ADDR_REQ_SELECT);

    drs_sync u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .lines_in  (periph_req),
        .lines_out (lines_s)
    );

    drs_mux u_mux (
        .lines  (lines_s),
        .source (ctrl_q.source),
        .picked (picked)
    );

    // ----------------------------------------
    // Request edge
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            picked_q <= 1'b0;
        else
            picked_q <= picked;
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q.source     <= drs_pkg::SRC_RESET;
            ctrl_q.force_trig <= 1'b0;
        end
        else
        begin
            if (wr_hit)
                ctrl_q.source <= pwdata[drs_pkg::SRC_W-1:0];
            if (wr_hit && pwdata[drs_pkg::FORCE_BIT])
                ctrl_q.force_trig <= 1'b1;
            else if (state_q == drs_pkg::ST_BUSY && forced_q && xfer_done)
                ctrl_q.force_trig <= 1'b0;
        end
    end

    // ----------------------------------------
    // Transfer sequencer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q                  <= drs_pkg::ST_IDLE;
            channel_transfer_request <= 1'b0;
            forced_q                 <= 1'b0;
        end
        else
        begin
            channel_transfer_request <= 1'b0;
            unique case (state_q)
                drs_pkg::ST_IDLE:
                begin
                    if (ctrl_q.force_trig)
                    begin
                        state_q                  <= drs_pkg::ST_BUSY;
                        channel_transfer_request <= 1'b1;
                        forced_q                 <= 1'b1;
                    end
                    else if (picked && !picked_q)
                    begin
                        state_q                  <= drs_pkg::ST_BUSY;
                        channel_transfer_request <= 1'b1;
                        forced_q                 <= 1'b0;
                    end
                end
                drs_pkg::ST_BUSY:
                begin
                    if (xfer_done)
                        state_q <= drs_pkg::ST_IDLE;
                end
                default:
                    state_q <= drs_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= psel & ~penable;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (paddr == drs_pkg::ADDR_REQ_SELECT)
            begin
                if (!pwrite)
                begin
                    prdata[drs_pkg::FORCE_BIT]   <= ctrl_q.force_trig;
                    prdata[drs_pkg::SRC_W-1:0]   <= ctrl_q.source;
                end
            end
            else if (paddr == drs_pkg::ADDR_STATUS)
            begin
                if (!pwrite)
                    prdata[drs_pkg::BUSY_BIT] <= (state_q == drs_pkg::ST_BUSY);
            end
            else
                pslverr <= 1'b1;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_force_start;
        @(posedge pclk) disable iff (!presetn)
        (state_q == drs_pkg::ST_IDLE && ctrl_q.force_trig) |=> channel_transfer_request;
    endproperty
    a_force_start: assert property (p_force_start) else $error("forced start missing");

    property p_one_forced;
        @(posedge pclk) disable iff (!presetn)
        (channel_transfer_request && forced_q) |=> !channel_transfer_request;
    endproperty
    a_one_forced: assert property (p_one_forced) else $error("double forced start");

    property p_auto_cause;
        @(posedge pclk) disable iff (!presetn)
        (channel_transfer_request && !forced_q) |-> $past(picked && !picked_q);
    endproperty
    a_auto_cause: assert property (p_auto_cause) else $error("start without request");

    property p_zero_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_hit && !pwdata[drs_pkg::FORCE_BIT] && ctrl_q.force_trig && !xfer_done)
        |=> ctrl_q.force_trig;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("trigger cleared by write");

    property p_auto_clear;
        @(posedge pclk) disable iff (!presetn)
        (state_q == drs_pkg::ST_BUSY && forced_q && xfer_done
         && !(wr_hit && pwdata[drs_pkg::FORCE_BIT])) |=> !ctrl_q.force_trig;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("trigger not cleared");

    property p_select;
        @(posedge pclk) disable iff (!presetn)
        picked == |(lines_s & ({{(drs_pkg::NUM_LINES-1){1'b0}}, 1'b1} << ctrl_q.source));
    endproperty
    a_select: assert property (p_select) else $error("wrong line picked");

    property p_reserved;
        @(posedge pclk) disable iff (!presetn)
        pready |-> prdata[drs_pkg::RSV_HI:drs_pkg::RSV_LO] == '0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_live_read;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == drs_pkg::ADDR_REQ_SELECT)
        |=> prdata[drs_pkg::FORCE_BIT] == $past(ctrl_q.force_trig);
    endproperty
    a_live_read: assert property (p_live_read) else $error("stale trigger read");

    property p_force_first;
        @(posedge pclk) disable iff (!presetn)
        (state_q == drs_pkg::ST_IDLE && ctrl_q.force_trig) |=> forced_q;
    endproperty
    a_force_first: assert property (p_force_first) else $error("request beat trigger");

    property p_trig_set;
        @(posedge pclk) disable iff (!presetn)
        (wr_hit && pwdata[drs_pkg::FORCE_BIT]) |=> ctrl_q.force_trig;
    endproperty
    a_trig_set: assert property (p_trig_set) else $error("trigger not set");

    property p_trig_keep;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_q.force_trig && !(state_q == drs_pkg::ST_BUSY && forced_q && xfer_done))
        |=> ctrl_q.force_trig;
    endproperty
    a_trig_keep: assert property (p_trig_keep) else $error("trigger lost");

    property p_req_from_idle;
        @(posedge pclk) disable iff (!presetn)
        channel_transfer_request |-> state_q == drs_pkg::ST_BUSY && $past(state_q == drs_pkg::ST_IDLE);
    endproperty
    a_req_from_idle: assert property (p_req_from_idle) else $error("start while busy");

    property p_no_spur;
        @(posedge pclk) disable iff (!presetn)
        (state_q == drs_pkg::ST_IDLE && !ctrl_q.force_trig && !(picked && !picked_q))
        |=> !channel_transfer_request;
    endproperty
    a_no_spur: assert property (p_no_spur) else $error("spurious start");

    property p_busy_hold;
        @(posedge pclk) disable iff (!presetn)
        (state_q == drs_pkg::ST_BUSY && !xfer_done)
        |=> (state_q == drs_pkg::ST_BUSY && !channel_transfer_request);
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("second start in transfer");

    property p_src_write;
        @(posedge pclk) disable iff (!presetn)
        wr_hit |=> ctrl_q.source == $past(pwdata[drs_pkg::SRC_W-1:0]);
    endproperty
    a_src_write: assert property (p_src_write) else $error("source not written");

    property p_src_hold;
        @(posedge pclk) disable iff (!presetn)
        !wr_hit |=> $stable(ctrl_q.source);
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("source changed");

    property p_clear_done;
        @(posedge pclk) disable iff (!presetn)
        $fell(ctrl_q.force_trig) |-> $past(xfer_done && forced_q);
    endproperty
    a_clear_done: assert property (p_clear_done) else $error("early trigger clear");

    property p_live_status;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == drs_pkg::ADDR_STATUS)
        |=> prdata[drs_pkg::BUSY_BIT] == $past(state_q == drs_pkg::ST_BUSY);
    endproperty
    a_live_status: assert property (p_live_status) else $error("stale busy read");

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    c_forced: cover property (@(posedge pclk) disable iff (!presetn)
        channel_transfer_request && forced_q);
    c_auto: cover property (@(posedge pclk) disable iff (!presetn)
        channel_transfer_request && !forced_q);
    c_clear: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(ctrl_q.force_trig));
    c_zero_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr_hit && !pwdata[drs_pkg::FORCE_BIT] && ctrl_q.force_trig);
    c_top_line: cover property (@(posedge pclk) disable iff (!presetn)
        channel_transfer_request && !forced_q && (&ctrl_q.source));

endmodule

// ==== verif/drs_engine_model.sv ====
// Behavioural transfer engine at the far side of the channel
// Assumes one pclk domain and a one-cycle start pulse from the block
module drs_engine_model #(
    parameter int DELAY = 12
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Engine handshake
    input  wire logic start,
    output logic      xfer_done
);
    timeunit 1ns;
    timeprecision 1ns;

    int cnt_q;

    // ----------------------------------------
    // Transfer timer, one done pulse per start
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q     <= 0;
            xfer_done <= 1'b0;
        end
        else
        begin
            xfer_done <= (cnt_q == 1);
            if (start)
                cnt_q <= DELAY;
            else if (cnt_q != 0)
                cnt_q <= cnt_q - 1;
        end
    end
endmodule

// ==== verif/test_dma_channel_request_select.sv ====
// Self-checking bench for the channel request-select block
// Assumes drs_top on APB and the behavioural engine model
module test_dma_channel_request_select;
    timeunit 1ns;
    timeprecision 1ns;

    logic                          pclk, presetn, psel, penable, pwrite;
    logic                          pready, pslverr, xfer_done, channel_transfer_request;
    logic [11:0]                   paddr;
    logic [31:0]                   pwdata, prdata, rd, err;
    logic [drs_pkg::NUM_LINES-1:0] periph_req;
    int                            n_fail, comparisons, cyc, n_req, base;
    // Rows: written word, unselected line, expected read
    logic [31:0] rows [4][3] = '{'{32'h7f80, 32'h01, 32'h00}, '{32'h7fff, 32'h7e, 32'h7f},
                                 '{32'h0055, 32'h54, 32'h55}, '{32'h3f2a, 32'h00, 32'h2a}};

    drs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
                 .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                 .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
                 .channel_transfer_request(channel_transfer_request), .xfer_done(xfer_done));
    drs_engine_model eng (.pclk(pclk), .presetn(presetn),
                          .start(channel_transfer_request), .xfer_done(xfer_done));

    // ----------------------------------------
    // Clock, request counter and timeout
    // ----------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (channel_transfer_request === 1'b1)
            n_req++;
        if (cyc == 4000)
        begin
            n_fail++;
            test_done;
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = {31'h0, pslverr};
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic [31:0] line);
        @(posedge pclk);
        periph_req[line[6:0]] <= 1'b1;
        repeat (4) @(posedge pclk);
        periph_req[line[6:0]] <= 1'b0;
        repeat (24) @(posedge pclk);
    endtask
    task automatic test_done;
        if (n_fail == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, periph_req} <= '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, drs_pkg::ADDR_REQ_SELECT, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, drs_pkg::ADDR_REQ_SELECT, rows[i][0]);
            apb(1'b0, drs_pkg::ADDR_REQ_SELECT, 32'h0);
            chk(rd, rows[i][2]);
            base = n_req;
            pulse(rows[i][1]);
            chk(n_req - base, 32'h0);
            pulse(rows[i][2]);
            chk(n_req - base, 32'h1);
        end
        // Forced transfer, then a zero write while it is pending
        base = n_req;
        apb(1'b1, drs_pkg::ADDR_REQ_SELECT, 32'h8011);
        apb(1'b1, drs_pkg::ADDR_REQ_SELECT, 32'h0011);
        apb(1'b0, drs_pkg::ADDR_REQ_SELECT, 32'h0);
        chk(rd, 32'h8011);
        apb(1'b0, drs_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h1);
        repeat (20) @(posedge pclk);
        apb(1'b0, drs_pkg::ADDR_REQ_SELECT, 32'h0);
        chk(rd, 32'h0011);
        chk(n_req - base, 32'h1);
        apb(1'b0, drs_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
        // Unmapped address
        apb(1'b0, 12'h008, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        // Reset in mid-run while a forced transfer is pending
        apb(1'b1, drs_pkg::ADDR_REQ_SELECT, 32'h8033);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk({30'h0, pready, channel_transfer_request}, 32'h0);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, drs_pkg::ADDR_REQ_SELECT, 32'h0);
        chk(rd, 32'h0);
        base = n_req;
        pulse(32'h0);
        chk(n_req - base, 32'h1);
        test_done;
    end
endmodule
